// File: test/srsx_exec_props.sv
// Assertion checker for the set-register and sleep execution unit.
`timescale 1ns/1ps
`default_nettype none
module srsx_exec_props (
  input wire logic               mclk, rst_n, instr_valid, wake_event,
  input wire logic               wake_by_watchdog, watchdog_clear,
  input wire logic               postscaler_clear, osc_stop, sleeping,
  input wire logic               power_down_flag, time_out_flag, instr_done,
  input wire logic [15:0]        instr_word,
  input wire logic [3:0]         bank_select_register,
  input wire srsx_pkg::srsx_wr_t reg_wr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence done_s; instr_done ##1 !instr_done; endsequence
  sequence clr_s; postscaler_clear ##1 !watchdog_clear; endsequence
  AST_ONES: assert property (reg_wr.wr |-> reg_wr.data == 8'hFF)
    else $error("write data not all ones");
  AST_BANK: assert property (reg_wr.wr |-> reg_wr.addr ==
    ($past(instr_word[8], 4) ? {$past(bank_select_register, 3),
    $past(instr_word[7:0], 4)} : {{4{$past(instr_word[7], 4)}},
    $past(instr_word[7:0], 4)})) else $error("wrong write address");
  AST_FLAGS: assert property (watchdog_clear |-> sleeping &&
    !power_down_flag && time_out_flag) else $error("bad sleep flags");
  AST_WDCLR: assert property (watchdog_clear |-> clr_s)
    else $error("watchdog clear pulse wrong");
  AST_HALT: assert property (sleeping && $past(sleeping) |->
    !reg_wr.wr && !instr_done && osc_stop) else $error("ran while asleep");
  AST_WAKE: assert property (sleeping && wake_event |-> ##[1:4]
    !sleeping) else $error("no wake-up");
  AST_WDWAKE: assert property ($fell(time_out_flag) |->
    $fell(sleeping)) else $error("time-out flag cleared off wake");
  AST_PULSE: assert property (reg_wr.wr |-> done_s)
    else $error("write not one cycle with done");
endmodule
bind srsx_exec srsx_exec_props u_props (.*);
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the set-register and sleep execution unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               mclk = 1'h0, rst_n = 1'h0, instr_valid = 1'h0;
  logic               wake_event = 1'h0, wake_by_watchdog = 1'h0;
  logic [15:0]        instr_word = 16'h0000;
  logic [3:0]         bank_select_register = 4'h0;
  srsx_pkg::srsx_wr_t reg_wr;
  logic               watchdog_clear, postscaler_clear, osc_stop, sleeping;
  logic               power_down_flag, time_out_flag, instr_done;
  int                 err_total = 0, checked = 0, cyc = 0;
  srsx_exec dut (.*);
  initial forever #2 mclk = ~mclk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The word is offered at a Q1 edge and results are read four edges on.
  task automatic op(logic [15:0] w, logic [3:0] b);
    instr_word = w;
    bank_select_register = b;
    instr_valid = 1'h1;
    @(posedge mclk) #1 instr_valid = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_set(logic a, logic [3:0] b, logic [7:0] f);
    op({7'h34, a, f}, b);
    chk("wr", reg_wr.wr, 16'h0001);
    chk("done", instr_done, 16'h0001);
    chk("addr", reg_wr.addr, a ? {b, f} : {{4{f[7]}}, f});
    chk("data", reg_wr.data, 16'h00FF);
    repeat (3) @(posedge mclk);
    #1 $display("set test done");
  endtask
  task automatic t_sleep;
    op(16'h0003, 4'h0);
    chk("sleeping", sleeping, 16'h0001);
    chk("osc", osc_stop, 16'h0001);
    chk("power_down_flag", power_down_flag, 16'h0000);
    chk("time_out_flag", time_out_flag, 16'h0001);
    chk("wdclr", watchdog_clear, 16'h0001);
    chk("psclr", postscaler_clear, 16'h0001);
    op(16'h6812, 4'h0);
    chk("wr asleep", reg_wr.wr, 16'h0000);
    wake_by_watchdog = 1'h1;
    wake_event = 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk("awake", sleeping, 16'h0000);
    chk("time_out_flag wake", time_out_flag, 16'h0000);
    $display("sleep test done");
  endtask
  // A wake-up that is not the watchdog's must leave the time-out flag set.
  task automatic t_wake_pin;
    wake_event = 1'h0;
    wake_by_watchdog = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    op(16'h0003, 4'h0);
    chk("sleeping again", sleeping, 16'h0001);
    chk("time_out_flag entry", time_out_flag, 16'h0001);
    wake_event = 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk("awake pin", sleeping, 16'h0000);
    chk("time_out_flag pin", time_out_flag, 16'h0001);
    $display("pin wake test done");
  endtask
  // A hang ends the run as a failure rather than stalling it.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'h1;
    t_set(1'h0, 4'h5, 8'h7F);
    t_set(1'h0, 4'h5, 8'h80);
    t_set(1'h1, 4'hA, 8'h3C);
    t_sleep();
    t_wake_pin();
    conclude();
  end
endmodule
`default_nettype wire

// File: verilog/srsx_decode.sv
// Instruction word decoder for the set-register and sleep operations.
`timescale 1ns/1ps
`default_nettype none
module srsx_decode (
  input  wire logic [15:0]        word,
  output var srsx_pkg::srsx_dec_t dec
);
  always_comb begin
    dec.is_set   = (word[15:9] == srsx_pkg::SETREG_PREFIX);
    dec.is_sleep = (word == srsx_pkg::SLEEP_WORD);
    dec.access   = word[srsx_pkg::ACCESS_POS];
    dec.f        = word[7:0];
  end
endmodule
`default_nettype wire

// File: verilog/srsx_exec.sv
// Execution unit for the set-register-all-ones and sleep instructions.
// How it works
// - Set instruction writes 8'hFF to the addressed data register.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Sleep clears the power-down flag and sets the time-out flag.
// - Sleep clears the watchdog counter and its postscaler.
// - After sleep the core halts, oscillator stopped, until a wake-up.
// - A watchdog wake-up clears the time-out flag set on entry.
`timescale 1ns/1ps
`default_nettype none
module srsx_exec (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        wake_event,
  input  wire logic        wake_by_watchdog,
  output var srsx_pkg::srsx_wr_t reg_wr,
  output logic             watchdog_clear,
  output logic             postscaler_clear,
  output logic             osc_stop,
  output logic             sleeping,
  output logic             power_down_flag,
  output logic             time_out_flag,
  output logic             instr_done
);
  srsx_pkg::srsx_phase_t phase_r;
  srsx_pkg::srsx_dec_t   dec;
  srsx_pkg::srsx_dec_t   dec_r;
  logic                  busy_r;
  logic [11:0]           addr_r;
  logic                  wake_s1_r;
  logic                  wake_s2_r;
  logic                  wdog_s1_r;
  logic                  wdog_s2_r;

  function automatic logic [11:0] resolve_addr(input logic a,
                                               input logic [7:0] f,
                                               input logic [3:0] bank);
    if (a) begin
      resolve_addr = {bank, f};
    end else if (f < srsx_pkg::ACCESS_SPLIT) begin
      resolve_addr = {srsx_pkg::BANK_RESET, f};
    end else begin
      resolve_addr = {srsx_pkg::ACCESS_HI_BANK, f};
    end
  endfunction

  srsx_decode u_dec (
    .word (instr_word),
    .dec  (dec)
  );

  // Wake inputs arrive from the asynchronous wake logic, so synchronise.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wdog_s1_r <= 1'b0;
      wdog_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_event;
      wake_s2_r <= wake_s1_r;
      wdog_s1_r <= wake_by_watchdog;
      wdog_s2_r <= wdog_s1_r;
    end
  end

  // The four-phase cycle runs only while awake; a new word is taken in Q1.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_r <= srsx_pkg::SRSX_Q1;
      busy_r  <= 1'b0;
      dec_r   <= '0;
    end else if (sleeping) begin
      phase_r <= srsx_pkg::SRSX_Q1;
      busy_r  <= 1'b0;
    end else begin
      case (phase_r)
        srsx_pkg::SRSX_Q1: begin
          busy_r  <= instr_valid;
          dec_r   <= dec;
          phase_r <= instr_valid ? srsx_pkg::SRSX_Q2 : srsx_pkg::SRSX_Q1;
        end
        srsx_pkg::SRSX_Q2: phase_r <= srsx_pkg::SRSX_Q3;
        srsx_pkg::SRSX_Q3: phase_r <= srsx_pkg::SRSX_Q4;
        default: begin
          phase_r <= srsx_pkg::SRSX_Q1;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // The bank is latched in Q2 so a late bank change cannot move the write.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (phase_r == srsx_pkg::SRSX_Q2) begin
      addr_r <= resolve_addr(dec_r.access, dec_r.f,
                             bank_select_register);
    end
  end

  // Register write leaves in Q4 as a one-cycle strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_wr <= '0;
    end else begin
      reg_wr.wr   <= busy_r && dec_r.is_set &&
                     (phase_r == srsx_pkg::SRSX_Q4);
      reg_wr.addr <= addr_r;
      reg_wr.data <= srsx_pkg::ALL_ONES;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= busy_r && (phase_r == srsx_pkg::SRSX_Q4);
    end
  end

  // Sleep entry in Q4; only a synchronised wake event leaves it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sleeping         <= 1'b0;
      osc_stop         <= 1'b0;
      watchdog_clear   <= 1'b0;
      postscaler_clear <= 1'b0;
    end else begin
      watchdog_clear   <= 1'b0;
      postscaler_clear <= 1'b0;
      if (sleeping && wake_s2_r) begin
        sleeping <= 1'b0;
        osc_stop <= 1'b0;
      end else if (busy_r && dec_r.is_sleep &&
                   phase_r == srsx_pkg::SRSX_Q4) begin
        sleeping         <= 1'b1;
        osc_stop         <= 1'b1;
        watchdog_clear   <= 1'b1;
        postscaler_clear <= 1'b1;
      end
    end
  end

  // Both flags are active low status bits, held high after reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_down_flag <= srsx_pkg::PWRDN_RESET;
      time_out_flag   <= srsx_pkg::TIMEOUT_RESET;
    end else if (sleeping && wake_s2_r && wdog_s2_r) begin
      time_out_flag <= 1'b0;
    end else if (busy_r && dec_r.is_sleep &&
                 phase_r == srsx_pkg::SRSX_Q4) begin
      power_down_flag <= 1'b0;
      time_out_flag   <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: verilog/srsx_pkg.sv
// Package with constants and carrier types of the set-register and sleep unit.
`default_nettype none
package srsx_pkg;
  localparam logic [15:0] SLEEP_WORD     = 16'h0003;
  localparam logic [6:0]  SETREG_PREFIX  = 7'h34;
  localparam int          ACCESS_POS     = 8;
  localparam logic [7:0]  ALL_ONES       = 8'hFF;
  localparam logic [7:0]  WATCHDOG_CLEAR = 8'h00;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  BANK_RESET     = 4'h0;
  localparam logic        TIMEOUT_RESET  = 1'b1;
  localparam logic        PWRDN_RESET    = 1'b1;

  typedef enum logic [1:0] {
    SRSX_Q1 = 2'b00,
    SRSX_Q2 = 2'b01,
    SRSX_Q3 = 2'b11,
    SRSX_Q4 = 2'b10
  } srsx_phase_t;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  data;
  } srsx_wr_t;

  typedef struct packed {
    logic is_set;
    logic is_sleep;
    logic access;
    logic [7:0] f;
  } srsx_dec_t;
endpackage
`default_nettype wire
